// [logic/wrec_cfg.svh]
`ifndef WREC_CFG_SVH
`define WREC_CFG_SVH
`define WREC_SAMPLE_BYTES 4
`define WREC_STORE_BYTES 64306588
`define WREC_DIG_RATE_HZ 200
`define WREC_DIG_PERIOD_MS 5
`define WREC_CLK_HZ 10000000
`define WREC_DIG_TICK_CYC ((`WREC_CLK_HZ / 1000) * `WREC_DIG_PERIOD_MS)
`define WREC_MS_CYC (`WREC_CLK_HZ / 1000)
`define WREC_SPC_64 2'h0
`define WREC_SPC_32 2'h1
`define WREC_SPC_16 2'h2
`define WREC_SPC_8 2'h3
`define WREC_EV_TRIG_ON 4'h0
`define WREC_EV_TRIG_OFF 4'h1
`define WREC_EV_MEM_CLR 4'h2
`define WREC_EV_OLD_CLR 4'h3
`define WREC_EV_FULL_ON 4'h4
`define WREC_EV_FULL_OFF 4'h5
`define WREC_EV_REC_ON 4'h6
`define WREC_EV_REC_OFF 4'h7
`define WREC_EV_STO_ON 4'h8
`define WREC_EV_STO_OFF 4'h9
`define WREC_EV_NEW_CLR 4'hA
`define WREC_NUM_EV 11
`endif

// [logic/wrec_pkg.sv]
`default_nettype none
package wrec_pkg;
  typedef enum logic [1:0] {
    WREC_DIV_IDLE = 2'b00,
    WREC_DIV_RUN = 2'b01,
    WREC_DIV_DONE = 2'b11
  } wrec_div_e;

  typedef struct packed {
    logic [7:0] nominalHz;
    logic [4:0] analogChannelCount;
    logic [6:0] digitalChannelCount;
    logic [1:0] samplesPerCycle;
    logic replaceMode;
    logic [31:0] preTrigMs;
  } wrec_cfg_s;

  typedef struct packed {
    logic valid;
    logic [3:0] code;
    logic [31:0] stamp;
  } wrec_event_s;

  typedef struct packed {
    logic trigger;
    logic memClear;
    logic oldClear;
    logic newClear;
    logic recordDone;
    logic storeDone;
  } wrec_cmd_s;
endpackage : wrec_pkg
`default_nettype wire

// [logic/wrec_recorder_event_block.sv]
`include "wrec_cfg.svh"
`default_nettype none
// Functional notes
// R01: Each stored sample word is four bytes; capacity is free bytes over four.
// R02: Each analog sampling instant stores one extra timestamp word; the code drops an instant's words when a digital tick coincides.
// R03: Digital channels are sampled at fixed 200 Hz, every 5 ms.
// R04: After configuration load, compute total recording time from the capacity formula.
// R05: Recordings share one 64 MB store; figure assumes no other files.
// R06: Raise events for trigger, clears, memory full, recording and storing changes.
// R07: Status events are never masked.
// R08: Every status event carries a timestamp of the change; the code stamps each with stampMs when it leaves the queue.
// R09: When full, replace mode drops oldest; keep mode refuses new recordings.
// R10: Analog rate selects 64, 32, 16 or 8 samples per cycle, default 64.
// R11: Never report ready while the maximum recording length is zero.
// R12: Keep a circular pre-trigger window so earlier samples join each recording.
module wrec_recorder_event_block
  import wrec_pkg::*;
#(
  parameter int unsigned STORE_BYTES = `WREC_STORE_BYTES,
  parameter int unsigned DIG_TICK_CYC = `WREC_DIG_TICK_CYC,
  parameter int unsigned MS_CYC = `WREC_MS_CYC,
  parameter int unsigned MAX_RECORDS = 64
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic clockEnable,
  input wire logic cfgLoad,
  input wire wrec_cfg_s cfgIn,
  input wire logic triggerSelected,
  input wire logic [31:0] recordLenMs,
  input wire wrec_cmd_s cmdIn,
  input wire logic analogInstant,
  output logic [31:0] totalTimeSec,
  output logic [31:0] captureCapacity,
  output logic recorderReady,
  output logic memoryFull,
  output logic recordingActive,
  output logic storingActive,
  output logic digitalTick,
  output logic [31:0] wordsPerInstant,
  output logic [31:0] preTrigWords,
  output wrec_event_s eventOut
);
  typedef struct packed {
    wrec_div_e divState;
    logic [31:0] num;
    logic [31:0] den;
    logic [31:0] quo;
    logic [5:0] bitIdx;
    logic [31:0] totalTime;
    logic [31:0] capacity;
    logic ready;
    logic trigLevel;
    logic full;
    logic recording;
    logic storing;
    logic [31:0] usedWords;
    logic [7:0] recCount;
    logic [31:0] curWords;
    logic [31:0] recMsCnt;
    logic [31:0] msCnt;
    logic [31:0] stampMs;
    logic [31:0] digCnt;
    logic digTick;
    logic [31:0] perInstant;
    logic [31:0] preWords;
    logic [31:0] preFill;
    logic [10:0] pending;
    wrec_event_s ev;
  } state_s;

  state_s s_q;
  state_s s_d;

  function automatic logic [6:0] spcValue(input logic [1:0] sel);
    case (sel)
      `WREC_SPC_64: spcValue = 7'h40;
      `WREC_SPC_32: spcValue = 7'h20;
      `WREC_SPC_16: spcValue = 7'h10;
      default: spcValue = 7'h08;
    endcase
  endfunction

  logic [31:0] remWide;
  logic [31:0] avgWordsPerMs;
  logic [3:0] evIdx;
  logic evFound;

  always_comb begin
    s_d = s_q;
    remWide = 32'h0;
    evIdx = 4'h0;
    evFound = 1'b0;
    avgWordsPerMs = 32'h0;
    // -----------------------------------------------------------------
    // Event drain first, so a fresh set of the same code in this cycle wins.
    // -----------------------------------------------------------------
    for (int i = `WREC_NUM_EV - 1; i >= 0; i--) begin
      if (s_q.pending[i]) begin
        evIdx = 4'(i);
        evFound = 1'b1;
      end
    end
    s_d.ev.valid = evFound;
    s_d.ev.code = evIdx;
    s_d.ev.stamp = s_q.stampMs; // [R08]
    if (evFound) begin
      s_d.pending[evIdx] = 1'b0;
    end
    // -----------------------------------------------------------------
    // Time base and digital sampling clock.
    // -----------------------------------------------------------------
    s_d.digTick = 1'b0;
    if (s_q.msCnt >= MS_CYC - 1) begin
      s_d.msCnt = 32'h0;
      s_d.stampMs = s_q.stampMs + 32'h1;
      if (s_q.recording) begin
        s_d.recMsCnt = s_q.recMsCnt + 32'h1;
      end
    end else begin
      s_d.msCnt = s_q.msCnt + 32'h1;
    end
    if (s_q.digCnt >= DIG_TICK_CYC - 1) begin // [R03]
      s_d.digCnt = 32'h0;
      s_d.digTick = 1'b1;
    end else begin
      s_d.digCnt = s_q.digCnt + 32'h1;
    end
    // -----------------------------------------------------------------
    // Capacity and total recording time after a configuration load.
    // -----------------------------------------------------------------
    case (s_q.divState)
      WREC_DIV_IDLE: begin
        if (cfgLoad) begin // [R04]
          s_d.capacity = STORE_BYTES / `WREC_SAMPLE_BYTES; // [R01] [R05]
          s_d.perInstant = 32'(cfgIn.analogChannelCount) + 32'h1; // [R02]
          s_d.num = STORE_BYTES / `WREC_SAMPLE_BYTES;
          s_d.den = 32'(cfgIn.nominalHz) * (32'(cfgIn.analogChannelCount) + 32'h1)
            * 32'(spcValue(cfgIn.samplesPerCycle))
            + 32'(`WREC_DIG_RATE_HZ) * 32'(cfgIn.digitalChannelCount); // [R10]
          s_d.quo = 32'h0;
          s_d.bitIdx = 6'h20;
          s_d.ready = 1'b0;
          s_d.divState = WREC_DIV_RUN;
        end
      end
      WREC_DIV_RUN: begin
        if (s_q.den == 32'h0) begin
          s_d.quo = 32'h0;
          s_d.divState = WREC_DIV_DONE;
        end else if (s_q.bitIdx == 6'h0) begin
          s_d.divState = WREC_DIV_DONE;
        end else begin
          remWide = s_q.num >> (s_q.bitIdx - 6'h1);
          if (remWide >= s_q.den) begin
            s_d.num = s_q.num - (s_q.den << (s_q.bitIdx - 6'h1));
            s_d.quo = s_q.quo | (32'h1 << (s_q.bitIdx - 6'h1));
          end
          s_d.bitIdx = s_q.bitIdx - 6'h1;
        end
      end
      WREC_DIV_DONE: begin
        s_d.totalTime = s_q.quo;
        s_d.preWords = 32'(cfgIn.nominalHz) * s_q.perInstant
          * 32'(spcValue(cfgIn.samplesPerCycle)) / 32'd1000 * cfgIn.preTrigMs; // [R12]
        s_d.ready = triggerSelected && (s_q.quo != 32'h0); // [R11]
        s_d.divState = WREC_DIV_IDLE;
      end
      default: s_d.divState = WREC_DIV_IDLE;
    endcase
    if (!triggerSelected) begin
      s_d.ready = 1'b0; // [R11]
    end
    // -----------------------------------------------------------------
    // Pre-trigger window fill while idle, capture and storage.
    // -----------------------------------------------------------------
    if (!s_q.recording && analogInstant && s_q.preFill < s_q.preWords) begin
      s_d.preFill = s_q.preFill + s_q.perInstant; // [R12]
    end
    if (s_q.recording && analogInstant) begin
      s_d.curWords = s_q.curWords + s_q.perInstant; // [R02]
    end
    if (s_q.recording && s_q.digTick) begin
      s_d.curWords = s_q.curWords + 32'(cfgIn.digitalChannelCount); // [R03]
    end
    s_d.trigLevel = cmdIn.trigger;
    if (cmdIn.trigger && !s_q.recording && !s_q.storing && s_q.ready) begin
      if (!s_q.full || cfgIn.replaceMode) begin // [R09]
        s_d.recording = 1'b1;
        s_d.curWords = s_q.preFill; // [R12]
        s_d.recMsCnt = 32'h0;
        if (s_q.full) begin
          s_d.pending[`WREC_EV_OLD_CLR] = 1'b1; // [R09]
          s_d.recCount = s_q.recCount - 8'h1;
          s_d.usedWords = s_q.usedWords - s_q.usedWords / 32'(s_q.recCount);
        end
      end
    end
    avgWordsPerMs = s_q.perInstant;
    if (s_q.recording && (cmdIn.recordDone || s_q.recMsCnt >= recordLenMs)) begin
      s_d.recording = 1'b0;
      s_d.storing = 1'b1;
    end
    if (s_q.storing && cmdIn.storeDone) begin
      s_d.storing = 1'b0;
      s_d.preFill = 32'h0;
      s_d.usedWords = s_d.usedWords + s_q.curWords;
      s_d.recCount = s_d.recCount + 8'h1;
    end
    if (cmdIn.memClear) begin
      s_d.usedWords = 32'h0;
      s_d.recCount = 8'h0;
      s_d.pending[`WREC_EV_MEM_CLR] = 1'b1;
    end else if ((cmdIn.oldClear || cmdIn.newClear) && s_q.recCount != 8'h0) begin
      s_d.usedWords = s_q.usedWords - s_q.usedWords / 32'(s_q.recCount);
      s_d.recCount = s_q.recCount - 8'h1;
      if (cmdIn.oldClear) begin
        s_d.pending[`WREC_EV_OLD_CLR] = 1'b1;
      end else begin
        s_d.pending[`WREC_EV_NEW_CLR] = 1'b1;
      end
    end
    s_d.full = (s_d.usedWords + avgWordsPerMs >= s_q.capacity && s_q.capacity != 32'h0)
      || (s_d.recCount >= 8'(MAX_RECORDS));
    // -----------------------------------------------------------------
    // Status events: all unmaskable, queued, each stamped.
    // -----------------------------------------------------------------
    if (s_d.trigLevel != s_q.trigLevel) begin // [R06] [R07]
      s_d.pending[s_d.trigLevel ? `WREC_EV_TRIG_ON : `WREC_EV_TRIG_OFF] = 1'b1;
    end
    if (s_d.full != s_q.full) begin // [R06]
      s_d.pending[s_d.full ? `WREC_EV_FULL_ON : `WREC_EV_FULL_OFF] = 1'b1;
    end
    if (s_d.recording != s_q.recording) begin // [R06]
      s_d.pending[s_d.recording ? `WREC_EV_REC_ON : `WREC_EV_REC_OFF] = 1'b1;
    end
    if (s_d.storing != s_q.storing) begin // [R06]
      s_d.pending[s_d.storing ? `WREC_EV_STO_ON : `WREC_EV_STO_OFF] = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else if (clockEnable) begin
      s_q <= s_d;
    end
  end

  assign totalTimeSec = s_q.totalTime;
  assign captureCapacity = s_q.capacity;
  assign recorderReady = s_q.ready;
  assign memoryFull = s_q.full;
  assign recordingActive = s_q.recording;
  assign storingActive = s_q.storing;
  assign digitalTick = s_q.digTick;
  assign wordsPerInstant = s_q.perInstant;
  assign preTrigWords = s_q.preWords;
  assign eventOut = s_q.ev;
endmodule : wrec_recorder_event_block
`default_nettype wire

// [testbench/wrec_checker.sv]
`include "wrec_cfg.svh"
`default_nettype none
module wrec_checker
  import wrec_pkg::*;
#(
  parameter int unsigned STORE_BYTES = 4,
  parameter int unsigned DIG_TICK_CYC = 2
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic clockEnable,
  input wire logic [31:0] totalTimeSec,
  input wire logic [31:0] captureCapacity,
  input wire logic recorderReady,
  input wire logic recordingActive,
  input wire logic storingActive,
  input wire logic digitalTick,
  input wire wrec_event_s eventOut
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // -------------------------------------------------------------
  // Cycles since the last digital tick, counted while enabled.
  // -------------------------------------------------------------
  int unsigned tickGap_q;
  logic tickSeen_q;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tickGap_q <= 0;
      tickSeen_q <= 1'b0;
    end else if (clockEnable) begin
      tickGap_q <= digitalTick ? 0 : tickGap_q + 1;
      tickSeen_q <= tickSeen_q | digitalTick;
    end
  end
  chk_tick_gap: assert property (clockEnable && digitalTick && tickSeen_q |->
    tickGap_q == DIG_TICK_CYC - 1)
    else $error("digital tick spacing wrong");
  chk_tick_one: assert property (clockEnable && digitalTick |=> !digitalTick)
    else $error("digital tick longer than one cycle");
  chk_cap_words: assert property (recorderReady |-> captureCapacity == STORE_BYTES / 4)
    else $error("capacity not bytes over four");
  chk_ready_len: assert property (recorderReady |-> totalTimeSec != 32'h0)
    else $error("ready with zero length");
  chk_rec_on: assert property ($rose(recordingActive) |->
    ##[1:4] (eventOut.valid && eventOut.code == `WREC_EV_REC_ON))
    else $error("no recording start event");
  chk_rec_off: assert property ($past(nrst) && $fell(recordingActive) |->
    ##[1:4] (eventOut.valid && eventOut.code == `WREC_EV_REC_OFF))
    else $error("no recording end event");
  chk_sto_on: assert property ($rose(storingActive) |->
    ##[1:4] (eventOut.valid && eventOut.code == `WREC_EV_STO_ON))
    else $error("no storing start event");
  chk_ev_stamp: assert property ($past(nrst) && eventOut.valid && $past(eventOut.valid) |->
    eventOut.stamp >= $past(eventOut.stamp))
    else $error("event stamp went back");
endmodule // wrec_checker
bind wrec_recorder_event_block wrec_checker #(
  .STORE_BYTES(STORE_BYTES),
  .DIG_TICK_CYC(DIG_TICK_CYC)
) chk_u (
  .clock(clock),
  .nrst(nrst),
  .clockEnable(clockEnable),
  .totalTimeSec(totalTimeSec),
  .captureCapacity(captureCapacity),
  .recorderReady(recorderReady),
  .recordingActive(recordingActive),
  .storingActive(storingActive),
  .digitalTick(digitalTick),
  .eventOut(eventOut)
);
`default_nettype wire

// [testbench/wrec_tb.sv]
`include "wrec_cfg.svh"
`default_nettype none
module tb;
  import wrec_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned CAP = `WREC_STORE_BYTES / `WREC_SAMPLE_BYTES;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic cfgLoad = 1'b0;
  logic clockEnable = 1'b1;
  logic triggerSelected = 1'b1;
  logic analogInstant = 1'b0;
  wrec_cfg_s cfgIn = {8'h32, 5'h09, 7'h02, 2'h0, 1'h1, 32'h2};
  wrec_cmd_s cmdIn = 6'h00;
  logic [31:0] totalTimeSec, captureCapacity, wordsPerInstant, preTrigWords, lastStamp;
  logic recorderReady, memoryFull, recordingActive, storingActive, digitalTick;
  wrec_event_s eventOut;
  int mismatches = 0;
  int numChecks = 0;
  wrec_recorder_event_block #(.DIG_TICK_CYC(5), .MS_CYC(1), .MAX_RECORDS(2)) dut_u (
    .clock(clock), .nrst(nrst), .clockEnable(clockEnable), .cfgLoad(cfgLoad), .cfgIn(cfgIn),
    .triggerSelected(triggerSelected), .recordLenMs(32'h000F4240), .cmdIn(cmdIn),
    .analogInstant(analogInstant), .totalTimeSec(totalTimeSec),
    .captureCapacity(captureCapacity), .recorderReady(recorderReady),
    .memoryFull(memoryFull), .recordingActive(recordingActive),
    .storingActive(storingActive), .digitalTick(digitalTick),
    .wordsPerInstant(wordsPerInstant), .preTrigWords(preTrigWords), .eventOut(eventOut));
  initial begin
    forever #50 clock = ~clock;
  end
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // -------------------------------------------------------------
  // Scenarios.
  // -------------------------------------------------------------
  task automatic load(input logic [1:0] spc);
    cfgIn.samplesPerCycle = spc;
    cfgLoad = 1'b1;
    @(negedge clock);
    cfgLoad = 1'b0;
    repeat (36) @(negedge clock);
  endtask
  task automatic test_capacity();
    load(2'h0);
    check_val(captureCapacity, CAP);
    check_val(totalTimeSec, CAP / (50 * 10 * 64 + 200 * 2));
    check_val(wordsPerInstant, 32'hA);
    check_val(preTrigWords, 32'h40);
    check_val({31'h0, recorderReady}, 32'h1);
  endtask
  task automatic test_freeze();
    clockEnable = 1'b0;
    cfgIn.analogChannelCount = 5'h03;
    load(2'h3);
    check_val(wordsPerInstant, 32'hA);
    check_val(totalTimeSec, CAP / (500 * 64 + 400));
    clockEnable = 1'b1;
    cfgIn.analogChannelCount = 5'h09;
  endtask
  task automatic test_rates();
    for (int i = 0; i < 4; i++) begin
      load(i[1:0]);
      check_val(totalTimeSec, CAP / (500 * (64 >> i) + 400));
    end
  endtask
  task automatic test_ready();
    triggerSelected = 1'b0;
    load(2'h0);
    check_val({31'h0, recorderReady}, 32'h0);
    triggerSelected = 1'b1;
    load(2'h0);
    check_val({31'h0, recorderReady}, 32'h1);
  endtask
  task automatic test_tick();
    int n = 0;
    repeat (50) begin
      @(negedge clock);
      analogInstant = ~analogInstant;
      n += digitalTick;
    end
    analogInstant = 1'b0;
    check_val(n, 32'hA);
  endtask
  task automatic expect_ev(input logic [3:0] code);
    int k = 0;
    @(negedge clock);
    while (eventOut.valid !== 1'b1 && k < 10) begin
      @(negedge clock);
      k++;
    end
    check_val({31'h0, eventOut.valid}, 32'h1);
    check_val({28'h0, eventOut.code}, {28'h0, code});
    check_val({31'h0, eventOut.stamp > lastStamp}, 32'h1);
    lastStamp = eventOut.stamp;
  endtask
  task automatic pulse(input wrec_cmd_s m);
    cmdIn = cmdIn | m;
    @(negedge clock);
    cmdIn = cmdIn & ~m;
  endtask
  task automatic rec_cycle(input logic wasFull, input logic nowFull);
    cmdIn.trigger = 1'b1;
    expect_ev(`WREC_EV_TRIG_ON);
    if (wasFull) begin
      expect_ev(`WREC_EV_OLD_CLR);
      expect_ev(`WREC_EV_FULL_OFF);
    end
    expect_ev(`WREC_EV_REC_ON);
    check_val({31'h0, recordingActive}, 32'h1);
    pulse(6'h02);
    expect_ev(`WREC_EV_REC_OFF);
    expect_ev(`WREC_EV_STO_ON);
    check_val({31'h0, storingActive}, 32'h1);
    cmdIn.trigger = 1'b0;
    expect_ev(`WREC_EV_TRIG_OFF);
    pulse(6'h01);
    if (nowFull) begin
      expect_ev(`WREC_EV_FULL_ON);
    end
    expect_ev(`WREC_EV_STO_OFF);
    check_val({31'h0, memoryFull}, {31'h0, nowFull});
  endtask
  task automatic test_events();
    lastStamp = 32'h0;
    rec_cycle(1'b0, 1'b0);
    rec_cycle(1'b0, 1'b1);
    rec_cycle(1'b1, 1'b1);
    cfgIn.replaceMode = 1'b0;
    cmdIn.trigger = 1'b1;
    expect_ev(`WREC_EV_TRIG_ON);
    repeat (3) @(negedge clock);
    check_val({31'h0, recordingActive}, 32'h0);
    cmdIn.trigger = 1'b0;
    expect_ev(`WREC_EV_TRIG_OFF);
    pulse(6'h08);
    expect_ev(`WREC_EV_OLD_CLR);
    expect_ev(`WREC_EV_FULL_OFF);
    pulse(6'h04);
    expect_ev(`WREC_EV_NEW_CLR);
    pulse(6'h10);
    expect_ev(`WREC_EV_MEM_CLR);
    check_val({31'h0, memoryFull}, 32'h0);
  endtask
  initial begin
    repeat (5) @(negedge clock);
    nrst = 1'b1;
    @(negedge clock);
    test_capacity();
    test_rates();
    test_ready();
    test_freeze();
    test_tick();
    test_events();
    summarize();
  end
  // The whole sequence needs well under a thousand cycles.
  initial begin
    #1000000;
    mismatches++;
    summarize();
  end
endmodule // tb
`default_nettype wire
